// ### logic/lsfsq_defines.svh
`ifndef LSFSQ_DEFINES_SVH
`define LSFSQ_DEFINES_SVH
// =============================================================
// Sizes and reset values
// =============================================================
`define LSFSQ_LANES       4
`define LSFSQ_MON_W       16
`define LSFSQ_TX_ATTRS    4
`define LSFSQ_RST_FLAGS   4'h0
`define LSFSQ_RST_CTRL    4'h0
// Monitored transmit attribute positions in the attribute index.
`define LSFSQ_ATTR_BIAS   0
`define LSFSQ_ATTR_POWER  1
`define LSFSQ_ATTR_TEMP   2
`define LSFSQ_ATTR_VOLT   3
`endif

// ### logic/lsfsq_pkg.sv
// =============================================================
// Types
// =============================================================
package lsfsq_pkg;
    typedef logic [3:0]  lsfsq_lane_t;
    typedef logic [15:0] lsfsq_mon_t;
endpackage

// ### logic/lsfsq_sync.sv
`timescale 1ns/1ps
`include "lsfsq_defines.svh"
// =============================================================
// Two-stage synchroniser for a lane-wide group of pin levels
// =============================================================
module lsfsq_sync
    import lsfsq_pkg::*;
(
    // Clock and reset.
    input  wire logic        i_core_clk,
    input  wire logic        i_reset_n,
    // Asynchronous levels in, synchronised levels out.
    input  wire lsfsq_lane_t i_async,
    output lsfsq_lane_t      o_sync
);
    typedef struct packed {
        lsfsq_lane_t first;
        lsfsq_lane_t second;
    } lsfsq_sync_t;

    lsfsq_sync_t state;
    lsfsq_sync_t next_state;

    // The second stage alone reads the first stage.
    always_comb begin
        next_state        = state;
        next_state.first  = i_async;
        next_state.second = state.first;
    end

    // State register.
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_sync = state.second;
endmodule

// ### logic/lsfsq_top.sv
`timescale 1ns/1ps
`include "lsfsq_defines.svh"
// Summary of operation
// - Out-of-threshold transmit bias, power, temperature or supply sets a sticky alarm flag.
// - Transmit input signal loss or transmitter fault sets a per-lane flag.
// - Receive optical input signal loss sets a per-lane flag.
// - Flags stay set after the cause has gone away.
// - Each flag group has a per-lane mask that blocks its interrupt.
// - A host read strobe of a flag group clears that group.
// - Transmit output squelches on input loss unless squelch is disabled.
// - Transmit lane is disabled on fault or host deactivation.
// - Receive output squelches on optical loss unless squelch is disabled.
// - Receive output squelches whenever the host deactivates the lane.
// - An interrupt output tells the host of alarm, loss or fault.
// - Status, flags and receive power monitor values are readable on output ports.
// - Per-lane disable and squelch-disable controls are host writable.
// - Four transmit and four receive lanes, independent except for the shared temperature and supply alarms.
// - Receive power is compared to thresholds and readable.
// - The management port is a target only; the host starts transfers.
module lsfsq_top
    import lsfsq_pkg::*;
(
    // Clock and reset.
    input  wire logic        i_core_clk,
    input  wire logic        i_reset_n,
    // Lane status pins from the analog front ends (asynchronous).
    input  wire lsfsq_lane_t i_tx_signal_loss_detect,
    input  wire lsfsq_lane_t i_tx_fault,
    input  wire lsfsq_lane_t i_rx_signal_loss_detect,
    // Monitor values from the converters (core clock domain).
    input  wire lsfsq_mon_t  i_tx_bias     [4],
    input  wire lsfsq_mon_t  i_tx_power    [4],
    input  wire lsfsq_mon_t  i_temp,
    input  wire lsfsq_mon_t  i_volt,
    input  wire lsfsq_mon_t  i_rx_power    [4],
    // Alarm thresholds, index is attribute (bias, power, temp, volt).
    input  wire lsfsq_mon_t  i_tx_thr_lo   [4],
    input  wire lsfsq_mon_t  i_tx_thr_hi   [4],
    input  wire lsfsq_mon_t  i_rx_thr_lo,
    input  wire lsfsq_mon_t  i_rx_thr_hi,
    // Host controls from the management target logic.
    input  wire lsfsq_lane_t i_tx_lane_disable,
    input  wire lsfsq_lane_t i_tx_squelch_disable,
    input  wire lsfsq_lane_t i_rx_lane_disable,
    input  wire lsfsq_lane_t i_rx_squelch_disable,
    input  wire lsfsq_lane_t i_tx_loss_mask,
    input  wire lsfsq_lane_t i_tx_fault_mask,
    input  wire lsfsq_lane_t i_rx_loss_mask,
    input  wire lsfsq_lane_t i_tx_alarm_mask,
    input  wire lsfsq_lane_t i_rx_alarm_mask,
    // Flag group read strobes, one cycle each.
    input  wire logic        i_rd_tx_flags,
    input  wire logic        i_rd_rx_flags,
    input  wire logic        i_rd_alarm_flags,
    // Latched flags and live status for host reads.
    output lsfsq_lane_t      o_tx_loss_flag,
    output lsfsq_lane_t      o_tx_fault_flag,
    output lsfsq_lane_t      o_rx_loss_flag,
    output lsfsq_lane_t      o_tx_alarm_flag,
    output lsfsq_lane_t      o_rx_alarm_flag,
    output lsfsq_lane_t      o_tx_status,
    output lsfsq_lane_t      o_rx_status,
    output lsfsq_mon_t       o_rx_power_rb [4],
    // Datapath controls and interrupt.
    output lsfsq_lane_t      o_tx_squelch,
    output lsfsq_lane_t      o_tx_disable,
    output lsfsq_lane_t      o_rx_squelch,
    output logic             o_int_n
);
    // =============================================================
    // Pin synchronisers
    // =============================================================
    lsfsq_lane_t tx_loss_s;
    lsfsq_lane_t tx_fault_s;
    lsfsq_lane_t rx_loss_s;

    lsfsq_sync u_sync_txl (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .i_async    (i_tx_signal_loss_detect),
        .o_sync     (tx_loss_s)
    );
    lsfsq_sync u_sync_txf (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .i_async    (i_tx_fault),
        .o_sync     (tx_fault_s)
    );
    lsfsq_sync u_sync_rxl (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .i_async    (i_rx_signal_loss_detect),
        .o_sync     (rx_loss_s)
    );

    // =============================================================
    // Threshold comparison
    // =============================================================
    // True when a value lies outside its low and high limits.
    function automatic logic out_of_range(lsfsq_mon_t v, lsfsq_mon_t lo, lsfsq_mon_t hi);
        return (v < lo) || (v > hi);
    endfunction

    lsfsq_lane_t tx_alarm_now;
    lsfsq_lane_t rx_alarm_now;

    // Each lane compares its own attributes; temp and volt are shared.
    genvar g;
    generate
        for (g = 0; g < `LSFSQ_LANES; g++) begin : g_cmp
            assign tx_alarm_now[g] =
                out_of_range(i_tx_bias[g], i_tx_thr_lo[`LSFSQ_ATTR_BIAS],
                             i_tx_thr_hi[`LSFSQ_ATTR_BIAS]) ||
                out_of_range(i_tx_power[g], i_tx_thr_lo[`LSFSQ_ATTR_POWER],
                             i_tx_thr_hi[`LSFSQ_ATTR_POWER]) ||
                out_of_range(i_temp, i_tx_thr_lo[`LSFSQ_ATTR_TEMP],
                             i_tx_thr_hi[`LSFSQ_ATTR_TEMP]) ||
                out_of_range(i_volt, i_tx_thr_lo[`LSFSQ_ATTR_VOLT],
                             i_tx_thr_hi[`LSFSQ_ATTR_VOLT]);
            assign rx_alarm_now[g] =
                out_of_range(i_rx_power[g], i_rx_thr_lo, i_rx_thr_hi);
        end
    endgenerate

    // =============================================================
    // State
    // =============================================================
    typedef struct packed {
        lsfsq_lane_t tx_loss_flag;
        lsfsq_lane_t tx_fault_flag;
        lsfsq_lane_t rx_loss_flag;
        lsfsq_lane_t tx_alarm_flag;
        lsfsq_lane_t rx_alarm_flag;
        lsfsq_lane_t tx_status;
        lsfsq_lane_t rx_status;
        lsfsq_mon_t  rxp0;
        lsfsq_mon_t  rxp1;
        lsfsq_mon_t  rxp2;
        lsfsq_mon_t  rxp3;
        lsfsq_lane_t tx_squelch;
        lsfsq_lane_t tx_disable;
        lsfsq_lane_t rx_squelch;
        logic        int_n;
    } lsfsq_state_t;

    lsfsq_state_t state;
    lsfsq_state_t next_state;
    lsfsq_lane_t  pend;

    // Sticky flags: a read clears a group, a new event in that cycle wins.
    always_comb begin
        next_state = state;
        next_state.tx_loss_flag  = (i_rd_tx_flags ? 4'h0 : state.tx_loss_flag)
                                 | tx_loss_s;
        next_state.tx_fault_flag = (i_rd_tx_flags ? 4'h0 : state.tx_fault_flag)
                                 | tx_fault_s;
        next_state.rx_loss_flag  = (i_rd_rx_flags ? 4'h0 : state.rx_loss_flag)
                                 | rx_loss_s;
        next_state.tx_alarm_flag = (i_rd_alarm_flags ? 4'h0 : state.tx_alarm_flag)
                                 | tx_alarm_now;
        next_state.rx_alarm_flag = (i_rd_alarm_flags ? 4'h0 : state.rx_alarm_flag)
                                 | rx_alarm_now;
        next_state.tx_status = tx_loss_s | tx_fault_s;
        next_state.rx_status = rx_loss_s;
        next_state.rxp0 = i_rx_power[0];
        next_state.rxp1 = i_rx_power[1];
        next_state.rxp2 = i_rx_power[2];
        next_state.rxp3 = i_rx_power[3];
        next_state.tx_squelch = tx_loss_s & ~i_tx_squelch_disable;
        next_state.tx_disable = tx_fault_s | i_tx_lane_disable;
        next_state.rx_squelch = (rx_loss_s & ~i_rx_squelch_disable)
                              | i_rx_lane_disable;
        next_state.int_n = ~|pend;
    end

    // Unmasked pending flags, taken from the next flag values.
    assign pend = (next_state.tx_loss_flag & ~i_tx_loss_mask)
                | (next_state.tx_fault_flag & ~i_tx_fault_mask)
                | (next_state.rx_loss_flag & ~i_rx_loss_mask)
                | (next_state.tx_alarm_flag & ~i_tx_alarm_mask)
                | (next_state.rx_alarm_flag & ~i_rx_alarm_mask);

    // State register; the interrupt idles released.
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state       <= '0;
            state.int_n <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // =============================================================
    // Outputs
    // =============================================================
    assign o_tx_loss_flag   = state.tx_loss_flag;
    assign o_tx_fault_flag  = state.tx_fault_flag;
    assign o_rx_loss_flag   = state.rx_loss_flag;
    assign o_tx_alarm_flag  = state.tx_alarm_flag;
    assign o_rx_alarm_flag  = state.rx_alarm_flag;
    assign o_tx_status      = state.tx_status;
    assign o_rx_status      = state.rx_status;
    assign o_rx_power_rb[0] = state.rxp0;
    assign o_rx_power_rb[1] = state.rxp1;
    assign o_rx_power_rb[2] = state.rxp2;
    assign o_rx_power_rb[3] = state.rxp3;
    assign o_tx_squelch     = state.tx_squelch;
    assign o_tx_disable     = state.tx_disable;
    assign o_rx_squelch     = state.rx_squelch;
    assign o_int_n          = state.int_n;

    // =============================================================
    // Assertions
    // =============================================================
    sequence s_loss_seen;
        !i_rd_tx_flags && (tx_loss_s != 4'h0);
    endsequence

    a_tx_loss_set: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        s_loss_seen |=> ((o_tx_loss_flag & $past(tx_loss_s)) == $past(tx_loss_s)))
        else $error("tx loss flag not set");
    a_flag_sticky: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        !i_rd_rx_flags |=> ((o_rx_loss_flag & $past(o_rx_loss_flag)) == $past(o_rx_loss_flag)))
        else $error("rx loss flag dropped without read");
    a_read_clear: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (i_rd_tx_flags && tx_fault_s == 4'h0) |=> (o_tx_fault_flag == 4'h0))
        else $error("tx fault flag not cleared by read");
    a_int_assert: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        ((o_rx_loss_flag & ~i_rx_loss_mask) != 4'h0 && !i_rd_rx_flags
         && $stable(i_rx_loss_mask)) |=> !o_int_n)
        else $error("interrupt missing for pending flag");
    a_int_masked: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (&i_tx_loss_mask && &i_tx_fault_mask && &i_rx_loss_mask && &i_tx_alarm_mask
         && &i_rx_alarm_mask) |=> o_int_n)
        else $error("masked sources raised interrupt");
    a_int_release: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (o_int_n == 1'b0) |-> (o_tx_loss_flag | o_tx_fault_flag | o_rx_loss_flag
         | o_tx_alarm_flag | o_rx_alarm_flag) != 4'h0)
        else $error("interrupt without latched flag");
    a_tx_squelch: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        1'b1 |=> (o_tx_squelch == ($past(tx_loss_s) & ~$past(i_tx_squelch_disable))))
        else $error("tx squelch wrong");
    a_tx_disable: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (tx_fault_s != 4'h0) |=> ((o_tx_disable & $past(tx_fault_s)) == $past(tx_fault_s)))
        else $error("faulted lane not disabled");
    a_rx_squelch: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        1'b1 |=> ((o_rx_squelch & ~$past(i_rx_lane_disable))
                  == ($past(rx_loss_s) & ~$past(i_rx_squelch_disable)
                      & ~$past(i_rx_lane_disable))))
        else $error("rx squelch wrong");
    a_rx_deact: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        1'b1 |=> ((o_rx_squelch & $past(i_rx_lane_disable)) == $past(i_rx_lane_disable)))
        else $error("deactivated rx lane not squelched");

    // Receive loss seen while no receive read strobe is present.
    sequence s_rx_loss_seen;
        !i_rd_rx_flags && (rx_loss_s != 4'h0);
    endsequence
    // Any threshold breach seen while no alarm read strobe is present.
    sequence s_alarm_seen;
        !i_rd_alarm_flags && ((tx_alarm_now | rx_alarm_now) != 4'h0);
    endsequence
    // An alarm read strobe that meets no live breach in either group.
    sequence s_alarm_read_idle;
        i_rd_alarm_flags && (tx_alarm_now == 4'h0) && (rx_alarm_now == 4'h0);
    endsequence

    a_rx_loss_set: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        s_rx_loss_seen |=> ((o_rx_loss_flag & $past(rx_loss_s)) == $past(rx_loss_s)))
        else $error("rx loss flag not set");
    a_tx_alarm_set: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        s_alarm_seen |=> ((o_tx_alarm_flag & $past(tx_alarm_now)) == $past(tx_alarm_now)))
        else $error("tx alarm flag not set");
    a_rx_alarm_set: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        s_alarm_seen |=> ((o_rx_alarm_flag & $past(rx_alarm_now)) == $past(rx_alarm_now)))
        else $error("rx alarm flag not set");
    a_read_alarm: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        s_alarm_read_idle |=> ((o_tx_alarm_flag | o_rx_alarm_flag) == 4'h0))
        else $error("alarm flags not cleared by read");
    a_read_rx: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (i_rd_rx_flags && rx_loss_s == 4'h0) |=> (o_rx_loss_flag == 4'h0))
        else $error("rx loss flag not cleared by read");
    a_status_follow: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        1'b1 |=> ((o_tx_status == ($past(tx_loss_s) | $past(tx_fault_s)))
                  && (o_rx_status == $past(rx_loss_s))))
        else $error("live status wrong");
    a_power_readback: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        1'b1 |=> (o_rx_power_rb[3] == $past(i_rx_power[3])))
        else $error("rx power readback wrong");
    a_tx_deact: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        1'b1 |=> ((o_tx_disable & $past(i_tx_lane_disable)) == $past(i_tx_lane_disable)))
        else $error("deactivated tx lane not disabled");
    a_lane_own: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        1'b1 |-> ((o_tx_fault_flag & ~$past(o_tx_fault_flag) & ~$past(tx_fault_s)) == 4'h0))
        else $error("fault flag set on a lane without its own cause");
    a_host_clear: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        !i_rd_tx_flags |=> ((o_tx_fault_flag & $past(o_tx_fault_flag))
                            == $past(o_tx_fault_flag)))
        else $error("tx fault flag cleared without host read");
    a_int_idle: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        ((o_tx_loss_flag | o_tx_fault_flag | o_rx_loss_flag | o_tx_alarm_flag
          | o_rx_alarm_flag) == 4'h0) |-> o_int_n)
        else $error("interrupt held with no flag set");
endmodule

// ### sim/lsfsq_host_model.sv
`timescale 1ns/1ps
// =============================================================
// Host controller on the management port
// =============================================================
module lsfsq_host_model (
    // Clock.
    input  wire logic i_core_clk,
    // Flag group read strobes towards the device.
    output logic      o_rd_tx_flags,
    output logic      o_rd_rx_flags,
    output logic      o_rd_alarm_flags
);
    // Strobes idle low until the host starts a read.
    initial begin
        o_rd_tx_flags    = 1'b0;
        o_rd_rx_flags    = 1'b0;
        o_rd_alarm_flags = 1'b0;
    end

    // Only the host starts a transfer; one strobe lasts one cycle.
    task automatic read_group(input int grp);
        @(posedge i_core_clk);
        o_rd_tx_flags    <= (grp == 0);
        o_rd_rx_flags    <= (grp == 1);
        o_rd_alarm_flags <= (grp == 2);
        @(posedge i_core_clk);
        o_rd_tx_flags    <= 1'b0;
        o_rd_rx_flags    <= 1'b0;
        o_rd_alarm_flags <= 1'b0;
        #1;
    endtask
endmodule

// ### sim/lsfsq_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin compares++; if ((ac) !== (ex)) begin num_errors++; \
    $display("Error %s expected %h seen %h", nm, ex, ac); end end
// =============================================================
// Self-checking bench for the lane flag and squelch block
// =============================================================
module lsfsq_tb_top
    import lsfsq_pkg::*;
;
    logic        i_core_clk = 1'b0;
    logic        i_reset_n  = 1'b0;
    lsfsq_lane_t tx_loss = 4'h0, tx_flt = 4'h0, rx_loss = 4'h0;
    lsfsq_mon_t  bias [4], pwr [4], rxp [4], lo [4], hi [4];
    lsfsq_mon_t  temp = 16'h0100, volt = 16'h0100;
    lsfsq_lane_t tx_dis = 4'h0, tx_sqd = 4'h0, rx_dis = 4'h0, rx_sqd = 4'h0;
    lsfsq_lane_t tx_lmsk = 4'h0, tx_fmsk = 4'h0, rx_lmsk = 4'h0;
    lsfsq_lane_t tx_amsk = 4'h0, rx_amsk = 4'h0;
    logic        rd_tx, rd_rx, rd_al;
    lsfsq_lane_t f_txl, f_txf, f_rxl, f_txa, f_rxa, st_tx, st_rx, sq_tx, dis_tx, sq_rx;
    lsfsq_mon_t  rb [4];
    logic        int_n;
    int          num_errors = 0;
    int          compares   = 0;

    // Monitor values sit inside their limits at time zero.
    initial begin
        for (int i = 0; i < 4; i++) begin
            bias[i] = 16'h0100;
            pwr[i]  = 16'h0100;
            rxp[i]  = 16'h0100;
            lo[i]   = 16'h0010;
            hi[i]   = 16'h1000;
        end
    end

    // Clock at 10 MHz.
    always #50 i_core_clk = ~i_core_clk;

    // Host side of the management port.
    lsfsq_host_model i_host (.i_core_clk(i_core_clk), .o_rd_tx_flags(rd_tx),
        .o_rd_rx_flags(rd_rx), .o_rd_alarm_flags(rd_al));

    lsfsq_top i_dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
        .i_tx_signal_loss_detect(tx_loss), .i_tx_fault(tx_flt),
        .i_rx_signal_loss_detect(rx_loss), .i_tx_bias(bias), .i_tx_power(pwr),
        .i_temp(temp), .i_volt(volt), .i_rx_power(rxp), .i_tx_thr_lo(lo),
        .i_tx_thr_hi(hi), .i_rx_thr_lo(lo[0]), .i_rx_thr_hi(hi[0]),
        .i_tx_lane_disable(tx_dis), .i_tx_squelch_disable(tx_sqd),
        .i_rx_lane_disable(rx_dis), .i_rx_squelch_disable(rx_sqd),
        .i_tx_loss_mask(tx_lmsk), .i_tx_fault_mask(tx_fmsk), .i_rx_loss_mask(rx_lmsk),
        .i_tx_alarm_mask(tx_amsk), .i_rx_alarm_mask(rx_amsk), .i_rd_tx_flags(rd_tx),
        .i_rd_rx_flags(rd_rx), .i_rd_alarm_flags(rd_al), .o_tx_loss_flag(f_txl),
        .o_tx_fault_flag(f_txf), .o_rx_loss_flag(f_rxl), .o_tx_alarm_flag(f_txa),
        .o_rx_alarm_flag(f_rxa), .o_tx_status(st_tx), .o_rx_status(st_rx),
        .o_rx_power_rb(rb), .o_tx_squelch(sq_tx), .o_tx_disable(dis_tx),
        .o_rx_squelch(sq_rx), .o_int_n(int_n));

    // Prints the counts and the verdict, then stops.
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Lets pin changes pass the synchroniser and reach the flags.
    task automatic settle();
        repeat (4) @(posedge i_core_clk);
        #1;
    endtask

    // Waits a bounded time for the interrupt line to reach a level.
    task automatic wait_int(input logic lvl);
        int n;
        n = 0;
        while (int_n !== lvl && n < 8) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        `CHK("int_n", lvl, int_n)
        if (int_n !== lvl) begin
            summarize();
        end
    endtask

    // Main sequence.
    initial begin
        repeat (6) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        settle();
        `CHK("reset flags", 4'h0, f_txf | f_txl | f_rxl)
        `CHK("reset int", 1'b1, int_n)
        $display("Test reset done");
        // Fault on lane 0: sticky flag, lane disabled, interrupt low.
        @(posedge i_core_clk);
        tx_flt <= 4'h1;
        settle();
        `CHK("tx fault flag", 4'h1, f_txf)
        `CHK("tx disable", 4'h1, dis_tx)
        `CHK("tx status", 4'h1, st_tx)
        wait_int(1'b0);
        @(posedge i_core_clk);
        tx_flt <= 4'h0;
        settle();
        `CHK("fault sticky", 4'h1, f_txf)
        wait_int(1'b0);
        i_host.read_group(0);
        `CHK("fault cleared", 4'h0, f_txf)
        wait_int(1'b1);
        $display("Test tx fault done");
        // Masked loss on lanes 1 and 2, squelch disabled on lane 2.
        @(posedge i_core_clk);
        tx_loss <= 4'h6;
        tx_sqd  <= 4'h4;
        tx_lmsk <= 4'hf;
        tx_dis  <= 4'h8;
        settle();
        `CHK("tx loss flag", 4'h6, f_txl)
        `CHK("tx squelch", 4'h2, sq_tx)
        `CHK("tx lane off", 4'h8, dis_tx)
        `CHK("masked int", 1'b1, int_n)
        @(posedge i_core_clk);
        tx_loss <= 4'h0;
        tx_dis  <= 4'h0;
        settle();
        i_host.read_group(0);
        `CHK("tx loss cleared", 4'h0, f_txl)
        $display("Test tx loss done");
        // Receive loss with squelch disable and lane disable.
        @(posedge i_core_clk);
        rx_loss <= 4'h3;
        rx_sqd  <= 4'h1;
        rx_dis  <= 4'h8;
        settle();
        `CHK("rx loss flag", 4'h3, f_rxl)
        `CHK("rx squelch", 4'ha, sq_rx)
        `CHK("rx status", 4'h3, st_rx)
        wait_int(1'b0);
        @(posedge i_core_clk);
        rx_loss <= 4'h0;
        settle();
        i_host.read_group(1);
        `CHK("rx loss cleared", 4'h0, f_rxl)
        wait_int(1'b1);
        $display("Test rx loss done");
        // Bias above limit on lane 2, receive power below limit on lane 0.
        @(posedge i_core_clk);
        bias[2] <= 16'h2000;
        rxp[0]  <= 16'h0001;
        settle();
        `CHK("tx alarm", 4'h4, f_txa)
        `CHK("rx alarm", 4'h1, f_rxa)
        `CHK("rx power", 16'h0001, rb[0])
        wait_int(1'b0);
        @(posedge i_core_clk);
        bias[2] <= 16'h0100;
        rxp[0]  <= 16'h0100;
        settle();
        i_host.read_group(2);
        `CHK("alarms cleared", 4'h0, f_txa | f_rxa)
        wait_int(1'b1);
        $display("Test alarms done");
        // Every source masked: shared temperature alarm, lane 1 fault, lane 2 loss.
        @(posedge i_core_clk);
        tx_fmsk <= 4'hf;
        rx_lmsk <= 4'hf;
        tx_amsk <= 4'hf;
        rx_amsk <= 4'hf;
        temp    <= 16'h2000;
        tx_flt  <= 4'h2;
        rx_loss <= 4'h4;
        rxp[3]  <= 16'h1100;
        settle();
        `CHK("shared alarm", 4'hf, f_txa)
        `CHK("rx alarm lane 3", 4'h8, f_rxa)
        `CHK("rx power 3", 16'h1100, rb[3])
        `CHK("masked fault", 4'h2, f_txf)
        `CHK("fault disable", 4'h2, dis_tx)
        `CHK("masked rx loss", 4'h4, f_rxl)
        `CHK("rx squelch mix", 4'hc, sq_rx)
        `CHK("all masked int", 1'b1, int_n)
        @(posedge i_core_clk);
        tx_amsk <= 4'h0;
        wait_int(1'b0);
        @(posedge i_core_clk);
        temp    <= 16'h0100;
        tx_flt  <= 4'h0;
        rx_loss <= 4'h0;
        rxp[3]  <= 16'h0100;
        settle();
        i_host.read_group(2);
        `CHK("masked alarms cleared", 4'h0, f_txa | f_rxa)
        wait_int(1'b1);
        i_host.read_group(0);
        i_host.read_group(1);
        `CHK("masked flags cleared", 4'h0, f_txf | f_rxl)
        $display("Test masks done");
        summarize();
    end

    // Cuts a hung run short.
    initial begin
        #5000000;
        num_errors++;
        summarize();
    end
endmodule
